// file: hw/sysref_pkg.sv
// constants, register map and types of the SYSREF generator control block
package sysref_pkg;
  // register word indices; byte address is four times the index
  localparam logic [9:0]  IDX_REQ         = 10'h00E;
  localparam logic [9:0]  IDX_CFG         = 10'h00F;
  localparam logic [9:0]  IDX_PULSE_DIV   = 10'h010;
  localparam logic [9:0]  IDX_MODE_OUT0   = 10'h011;
  localparam logic [9:0]  IDX_OUT1        = 10'h012;
  localparam logic [9:0]  IDX_STATUS      = 10'h020;
  // reset values
  localparam logic [15:0] RST_REQ         = 16'h0201;
  localparam logic [15:0] RST_CFG         = 16'h0800;
  localparam logic [15:0] RST_PULSE_DIV   = 16'h1005;
  localparam logic [15:0] RST_MODE_OUT0   = 16'h07F0;
  localparam logic [15:0] RST_OUT1        = 16'hFE00;
  // request register fields
  localparam int          REQ_CLEAR_BIT   = 0;
  localparam int          REQ_STEPS_LSB   = 1;
  localparam int          REQ_LATCH_BIT   = 7;
  localparam int          REQ_FORCE_BIT   = 8;
  localparam int          REQ_PINFN_BIT   = 9;
  localparam logic [15:0] REQ_WMASK       = 16'h03FF;
  // configuration register fields
  localparam int          CFG_BYPASS_BIT  = 0;
  localparam int          CFG_PRE_LSB     = 10;
  localparam logic [15:0] CFG_WMASK       = 16'h0C01;
  // pulse count and divider fields
  localparam int          PULSE_CNT_LSB   = 12;
  localparam int          DIV_LSB         = 0;
  // mode and output delay fields
  localparam int          MODE_LSB        = 0;
  localparam int          OUT0_PHASE_LSB  = 2;
  localparam int          OUT0_I_LSB      = 4;
  localparam logic [15:0] MODE_OUT0_WMASK = 16'h07FF;
  localparam int          OUT0_Q_LSB      = 0;
  localparam int          OUT1_PHASE_LSB  = 7;
  localparam int          OUT1_I_LSB      = 9;
  // shortest legal divide value
  localparam logic [11:0] DIV_MIN         = 12'h002;
  // delay line: one unit step is one clock cycle
  localparam int          REQ_STEP_MAX    = 63;

  typedef enum logic [1:0] {
    MODE_CONTINUOUS,
    MODE_PULSER,
    MODE_REPEATER,
    MODE_RESERVED
  } gen_mode_t;

  typedef enum logic [1:0] {
    RT_I_INV,
    RT_Q_INV,
    RT_I,
    RT_Q
  } retimer_t;
endpackage

// file: hw/align_divider_if.sv
// settings and output of the SYSREF divider shared between control and divider
`timescale 1ns/1ps
interface align_divider_if;
  logic [1:0]  prescale;
  logic [11:0] divide;
  logic        run;
  logic        restart;
  logic        div_out;
  modport ctrl (output prescale, output divide, output run, output restart, input div_out);
  modport gen  (input prescale, input divide, input run, input restart, output div_out);
endinterface

// file: hw/request_delay_line.sv
// programmable step delay for the alignment request input
`timescale 1ns/1ps
module request_delay_line
  import sysref_pkg::*;
#(
  parameter int DEPTH = REQ_STEP_MAX + 1
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clear,
  input  wire logic [5:0] request_step_count,
  input  wire logic       din,
  output logic            dout
);
  logic [DEPTH-1:0] taps;
  logic [DEPTH-1:0] next_taps;

  always_comb begin
    next_taps = clear ? '0 : {taps[DEPTH-2:0], din};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      taps <= '0;
    end else begin
      taps <= next_taps;
    end
  end

  // tap n gives n+1 cycles: one register plus n unit steps
  assign dout = taps[request_step_count];
endmodule // request_delay_line

// file: hw/align_divider.sv
// prescaler and SYSREF divider producing the divided alignment clock
`timescale 1ns/1ps
module align_divider (
  input  wire logic  pclk,
  input  wire logic  presetn,
  align_divider_if.gen  dv
);
  logic [1:0]  pre_cnt;
  logic [1:0]  next_pre_cnt;
  logic [1:0]  pre_lim;
  logic [11:0] cnt;
  logic [11:0] next_cnt;
  logic        out_q;
  logic        next_out;

  always_comb begin
    case (dv.prescale)
      2'h0:    pre_lim = 2'h0;
      2'h1:    pre_lim = 2'h1;
      default: pre_lim = 2'h3;
    endcase
    next_pre_cnt = pre_cnt;
    next_cnt     = cnt;
    if (!dv.run || dv.restart) begin
      next_pre_cnt = 2'h0;
      next_cnt     = 12'h000;
    end else if (pre_cnt >= pre_lim) begin
      next_pre_cnt = 2'h0;
      next_cnt     = (cnt >= dv.divide - 12'h001) ? 12'h000 : cnt + 12'h001;
    end else begin
      next_pre_cnt = pre_cnt + 2'h1;
    end
    // high for the lower half; odd divides give under half duty
    // a restart opens a full-width high phase, so the first pulse keeps its width
    next_out = dv.run && (next_cnt < (dv.divide >> 1));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 2'h0;
      cnt     <= 12'h000;
      out_q   <= 1'b0;
    end else begin
      pre_cnt <= next_pre_cnt;
      cnt     <= next_cnt;
      out_q   <= next_out;
    end
  end

  assign dv.div_out = out_q;
endmodule // align_divider

// file: hw/sysref_generator_control.sv
// SYSREF request path, divider control, pulser and repeater with APB registers
//
// Summary of operation
// - request delay is six bits; codes above 0x3F cannot be stored
// - delayed request copy lags by one cycle plus step count times the unit step
// - request clear empties the latch and flushes the delay line
// - clear high forces internal request low except in repeater mode, beats force
// - pulse count 1 to 15 sets pulser pulses; zero is reserved
// - pulser counter gates the divider output, keeping its width and rate
// - twelve-bit divider divides 2 to 4095; 0 and 1 reserved; resets to 5
// - mode field picks continuous, pulser or repeater; 3 reserved; bypass matters
// - continuous mode outputs the uninterrupted divider clock
// - pulser mode emits the programmed number of pulses per request
// - repeater mode gives one output pulse per request pulse
// - output zero phase: inverted I, inverted Q, I, Q
// - output one phase: inverted I, inverted Q, Q, I
// - pin function bit chooses sync input or request input; resets to 1
// - latch holds request high from first rising edge until clear
// - prescaler divides by 1, 2 or 4; code 3 reserved; resets to 2
`timescale 1ns/1ps
module sysref_generator_control
  import sysref_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              alignment_request_input,
  output logic                   align_output_zero,
  output logic                   align_output_one,
  output logic      [1:0]        out0_retimer,
  output logic      [1:0]        out1_retimer,
  output logic      [6:0]        out0_inphase_weight,
  output logic      [6:0]        out0_quadrature_weight,
  output logic      [6:0]        out1_inphase_weight,
  output logic                   sync_restart
);
  align_divider_if dv ();

  logic [15:0] reg_req;
  logic [15:0] reg_cfg;
  logic [15:0] reg_pulse_div;
  logic [15:0] reg_mode_out0;
  logic [15:0] reg_out1;
  logic [15:0] next_req;
  logic [15:0] next_cfg;
  logic [15:0] next_pulse_div;
  logic [15:0] next_mode_out0;
  logic [15:0] next_out1;
  logic [31:0] next_prdata;
  logic [9:0]  word;
  logic        hit;
  logic        wr_en;
  logic [15:0] rd_word;

  logic        request_clear;
  logic [5:0]  request_step_count;
  logic        request_latch;
  logic        request_force;
  logic        request_pin_function;
  logic        delay_generator_bypass;
  logic [1:0]  align_prescaler;
  logic [3:0]  pulser_count;
  logic [11:0] align_divider_value;
  gen_mode_t   align_generation_mode;
  logic [1:0]  out0_interp_phase;
  logic [1:0]  out1_interp_phase;

  logic        req_delayed;
  logic        req_delayed_q;
  logic        req_rise;
  logic        latched;
  logic        next_latched;
  logic        req_int;
  logic        req_int_q;
  logic        trig;
  logic        cfg_bad;
  logic        rep_pulse;
  logic        div_q;
  logic [3:0]  pulses_left;
  logic [3:0]  next_pulses_left;
  logic        gen;
  logic        gen_q;
  logic        next_out;
  logic        out_q;

  // field extraction
  assign request_clear          = reg_req[REQ_CLEAR_BIT];
  assign request_step_count     = reg_req[REQ_STEPS_LSB +: 6];
  assign request_latch          = reg_req[REQ_LATCH_BIT];
  assign request_force          = reg_req[REQ_FORCE_BIT];
  assign request_pin_function   = reg_req[REQ_PINFN_BIT];
  assign delay_generator_bypass = reg_cfg[CFG_BYPASS_BIT];
  assign align_prescaler        = reg_cfg[CFG_PRE_LSB +: 2];
  assign pulser_count           = reg_pulse_div[PULSE_CNT_LSB +: 4];
  assign align_divider_value    = reg_pulse_div[DIV_LSB +: 12];
  assign align_generation_mode  = gen_mode_t'(reg_mode_out0[MODE_LSB +: 2]);
  assign out0_interp_phase      = reg_mode_out0[OUT0_PHASE_LSB +: 2];
  assign out1_interp_phase      = reg_out1[OUT1_PHASE_LSB +: 2];
  assign out0_inphase_weight    = reg_mode_out0[OUT0_I_LSB +: 7];
  assign out0_quadrature_weight = reg_out1[OUT0_Q_LSB +: 7];
  assign out1_inphase_weight    = reg_out1[OUT1_I_LSB +: 7];

  // APB slave, zero wait states
  assign word    = paddr[ADDR_W-1:2];
  assign hit     = (word == IDX_REQ) || (word == IDX_CFG) || (word == IDX_PULSE_DIV) ||
                   (word == IDX_MODE_OUT0) || (word == IDX_OUT1) || (word == IDX_STATUS);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign wr_en   = psel && penable && pwrite;

  always_comb begin
    next_req       = reg_req;
    next_cfg       = reg_cfg;
    next_pulse_div = reg_pulse_div;
    next_mode_out0 = reg_mode_out0;
    next_out1      = reg_out1;
    if (wr_en) begin
      case (word)
        IDX_REQ:       next_req       = pwdata[15:0] & REQ_WMASK;
        IDX_CFG:       next_cfg       = pwdata[15:0] & CFG_WMASK;
        IDX_PULSE_DIV: next_pulse_div = pwdata[15:0];
        IDX_MODE_OUT0: next_mode_out0 = pwdata[15:0] & MODE_OUT0_WMASK;
        IDX_OUT1:      next_out1      = pwdata[15:0];
        default:       next_req       = reg_req;
      endcase
    end
    case (word)
      IDX_REQ:       rd_word = reg_req;
      IDX_CFG:       rd_word = reg_cfg;
      IDX_PULSE_DIV: rd_word = reg_pulse_div;
      IDX_MODE_OUT0: rd_word = reg_mode_out0;
      IDX_OUT1:      rd_word = reg_out1;
      IDX_STATUS:    rd_word = {8'h00, cfg_bad, out_q, pulses_left, latched, req_int};
      default:       rd_word = 16'h0000;
    endcase
    // read data captured in the setup cycle, valid through the access cycle
    next_prdata = (psel && !penable && !pwrite) ? {16'h0000, rd_word} : prdata;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_req       <= RST_REQ;
      reg_cfg       <= RST_CFG;
      reg_pulse_div <= RST_PULSE_DIV;
      reg_mode_out0 <= RST_MODE_OUT0;
      reg_out1      <= RST_OUT1;
      prdata        <= 32'h0000_0000;
    end else begin
      reg_req       <= next_req;
      reg_cfg       <= next_cfg;
      reg_pulse_div <= next_pulse_div;
      reg_mode_out0 <= next_mode_out0;
      reg_out1      <= next_out1;
      prdata        <= next_prdata;
    end
  end

  // request path
  request_delay_line u_delay (
    .pclk               (pclk),
    .presetn            (presetn),
    .clear              (request_clear),
    .request_step_count (request_step_count),
    .din                (alignment_request_input),
    .dout               (req_delayed)
  );

  assign req_rise = req_delayed && !req_delayed_q;

  always_comb begin
    next_latched = latched;
    if (request_clear) begin
      next_latched = 1'b0;
    end else if (request_latch && req_rise) begin
      next_latched = 1'b1;
    end
    if (request_clear && align_generation_mode != MODE_REPEATER) begin
      req_int = 1'b0;
    end else begin
      req_int = (request_latch ? latched : req_delayed) || request_force;
    end
  end

  // reserved codes keep the generator idle
  assign cfg_bad = (align_generation_mode == MODE_RESERVED) || (align_divider_value < DIV_MIN) ||
                   (align_prescaler == 2'h3) || (pulser_count == 4'h0);
  // request pins as sync input restart the divider, otherwise they trigger
  assign sync_restart = !request_pin_function && req_int && !req_int_q;
  assign trig         = request_pin_function && req_int && !req_int_q &&
                        align_generation_mode == MODE_PULSER && !cfg_bad;
  assign rep_pulse    = request_pin_function && req_rise &&
                        align_generation_mode == MODE_REPEATER && !cfg_bad;

  assign dv.prescale = align_prescaler;
  assign dv.divide   = align_divider_value;
  assign dv.run      = !cfg_bad && (align_generation_mode == MODE_CONTINUOUS ||
                                    align_generation_mode == MODE_PULSER);
  assign dv.restart  = trig || sync_restart;

  align_divider u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .dv      (dv.gen)
  );

  // pulser and mode selection
  always_comb begin
    next_pulses_left = pulses_left;
    if (align_generation_mode != MODE_PULSER || cfg_bad) begin
      next_pulses_left = 4'h0;
    end else if (trig) begin
      next_pulses_left = pulser_count;
    end else if (div_q && !dv.div_out && pulses_left != 4'h0) begin
      next_pulses_left = pulses_left - 4'h1;
    end
    case (align_generation_mode)
      MODE_CONTINUOUS: gen = dv.div_out;
      MODE_PULSER:     gen = dv.div_out && pulses_left != 4'h0;
      MODE_REPEATER:   gen = rep_pulse;
      default:         gen = 1'b0;
    endcase
    if (cfg_bad) begin
      gen = 1'b0;
    end
    // delay generators add one retiming stage unless bypassed
    next_out = delay_generator_bypass ? gen : gen_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_delayed_q <= 1'b0;
      req_int_q     <= 1'b0;
      latched       <= 1'b0;
      div_q         <= 1'b0;
      pulses_left   <= 4'h0;
      gen_q         <= 1'b0;
      out_q         <= 1'b0;
    end else begin
      req_delayed_q <= req_delayed;
      req_int_q     <= req_int;
      latched       <= next_latched;
      div_q         <= dv.div_out;
      pulses_left   <= next_pulses_left;
      gen_q         <= gen;
      out_q         <= next_out;
    end
  end

  assign align_output_zero = out_q;
  assign align_output_one  = out_q;

  // interpolator retimer selection
  assign out0_retimer = out0_interp_phase;
  always_comb begin
    case (out1_interp_phase)
      2'h0:    out1_retimer = RT_I_INV;
      2'h1:    out1_retimer = RT_Q_INV;
      2'h2:    out1_retimer = RT_Q;
      default: out1_retimer = RT_I;
    endcase
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_clear_blocks_req: assert property (request_clear && align_generation_mode != MODE_REPEATER |-> !req_int)
    else $error("internal request high while clear held");
  chk_clear_empties_latch: assert property (request_clear |=> !latched)
    else $error("latch not cleared by request clear");
  chk_latch_holds_high: assert property (latched && !request_clear |=> latched)
    else $error("latched request dropped without clear");
  chk_latch_sets_edge: assert property (request_latch && !request_clear && req_rise |=> latched)
    else $error("latch missed first rising edge");
  chk_pulser_loads_count: assert property (trig |=> pulses_left == $past(pulser_count))
    else $error("pulser count not loaded on request");
  chk_pulser_idle_done: assert property (align_generation_mode == MODE_PULSER && pulses_left == 4'h0 |-> !gen)
    else $error("pulser output active after count done");
  chk_reserved_idle_out: assert property (cfg_bad ##1 cfg_bad ##1 cfg_bad |-> !out_q)
    else $error("output active under reserved setting");
  chk_repeater_one_pulse: assert property (rep_pulse && delay_generator_bypass |=> out_q ##1 !out_q)
    else $error("repeater pulse not single");
  chk_continuous_follows: assert property (align_generation_mode == MODE_CONTINUOUS && !cfg_bad |-> gen == dv.div_out)
    else $error("continuous output differs from divider");
  chk_out1_phase_map: assert property (out1_interp_phase == 2'h2 |-> out1_retimer == RT_Q)
    else $error("output one phase map wrong");
  chk_delay_tap_time: assert property (!request_clear && !$past(request_clear) && $stable(request_step_count) &&
                                       request_step_count == 6'h00 |->
                                       req_delayed == $past(alignment_request_input))
    else $error("zero step delay not one cycle");
  chk_pulse_width_gate: assert property (align_generation_mode == MODE_PULSER && pulses_left != 4'h0 && !cfg_bad
                                         |-> gen == dv.div_out)
    else $error("pulser does not pass divider output");

  cov_repeater_pulse: cover property (rep_pulse ##2 out_q);
  cov_pulser_finish: cover property (trig ##[1:200] (pulses_left == 4'h0 && align_generation_mode == MODE_PULSER));
  cov_continuous_run: cover property (align_generation_mode == MODE_CONTINUOUS && $rose(out_q));
  cov_latch_set: cover property (request_latch && $rose(latched));
endmodule // sysref_generator_control

// file: testbench/sysref_partner.sv
// request source and output monitor at the far side of the SYSREF block
`timescale 1ns/1ps
module sysref_partner (
  input  wire logic pclk,
  input  wire logic out_zero,
  input  wire logic out_one,
  input  wire logic sync_pulse,
  output logic      req
);
  int   cyc      = 0;
  int   req_cyc  = 0;
  int   out_cyc  = 0;
  int   rises    = 0;
  int   highs    = 0;
  int   syncs    = 0;
  int   diffs    = 0;
  logic last_req = 1'b0;
  logic last_out = 1'b0;

  initial req = 1'b0;

  // request pulse of hi cycles, then a quiet gap
  task automatic send(input int hi);
    @(posedge pclk);
    req <= 1'b1;
    repeat (hi) @(posedge pclk);
    req <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  always @(posedge pclk) begin
    cyc      <= cyc + 1;
    last_req <= req;
    last_out <= out_zero;
    if (req && !last_req)
      req_cyc <= cyc;
    if (out_zero && !last_out) begin
      rises   <= rises + 1;
      out_cyc <= cyc;
    end
    if (out_zero)
      highs <= highs + 1;
    if (sync_pulse)
      syncs <= syncs + 1;
    if (out_zero !== out_one)
      diffs <= diffs + 1;
  end
endmodule // sysref_partner

// file: testbench/sysref_generator_control_tb.sv
// self-checking testbench of the SYSREF generator control block
`timescale 1ns/1ps
module sysref_generator_control_tb;
  import sysref_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, out0, out1, sync_restart;
  logic [1:0]  rt0, rt1;
  logic [6:0]  w0i, w0q, w1i;
  logic [15:0] rdata;
  logic        rerr;
  int          error_cnt = 0;
  int          compares  = 0;
  int          a, s, l0, l1, l2;

  sysref_generator_control dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .alignment_request_input(req), .align_output_zero(out0),
    .align_output_one(out1), .out0_retimer(rt0), .out1_retimer(rt1), .out0_inphase_weight(w0i),
    .out0_quadrature_weight(w0q), .out1_inphase_weight(w1i), .sync_restart(sync_restart));

  sysref_partner src (.pclk(pclk), .out_zero(out0), .out_one(out1), .sync_pulse(sync_restart),
    .req(req));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic close_out;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic apb(input logic [9:0] idx, input logic wr, input logic [15:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata[15:0];
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [9:0] idx, input logic [15:0] want);
    apb(idx, 1'b0, 16'h0000);
    check(what, rdata, want);
  endtask

  // clear pulse before any request is used
  task automatic arm(input logic [15:0] bits);
    apb(IDX_REQ, 1'b1, bits | 16'h0001);
    apb(IDX_REQ, 1'b1, bits & 16'hFFFE);
  endtask

  task automatic setup(input logic [1:0] pre, input logic bp, input logic [15:0] pdiv,
                       input logic [1:0] mode);
    apb(IDX_CFG, 1'b1, {4'h0, pre, 9'h000, bp});
    apb(IDX_PULSE_DIV, 1'b1, pdiv);
    apb(IDX_MODE_OUT0, 1'b1, {5'h00, 7'h7F, 2'h0, mode});
  endtask

  task automatic t_reset;
    rdchk("req reset", IDX_REQ, RST_REQ);
    rdchk("cfg reset", IDX_CFG, RST_CFG);
    rdchk("pulse div reset", IDX_PULSE_DIV, 16'h1005);
    rdchk("mode out0 reset", IDX_MODE_OUT0, 16'h07F0);
    rdchk("out1 reset", IDX_OUT1, 16'hFE00);
    check("w0i reset", w0i, 7'h7F);
    check("w0q reset", w0q, 7'h00);
    rdchk("unmapped read", 10'h01F, 16'h0000);
    check("unmapped err", rerr, 1'b1);
    apb(IDX_MODE_OUT0, 1'b1, 16'hFFFF);
    rdchk("read only bits", IDX_MODE_OUT0, 16'h07FF);
  endtask

  task automatic t_retimer;
    logic [1:0] exp1 [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    for (int p = 0; p < 4; p++) begin
      apb(IDX_MODE_OUT0, 1'b1, {5'h00, 7'h40, p[1:0], 2'h0});
      apb(IDX_OUT1, 1'b1, {7'h20, p[1:0], 7'h3F});
      @(negedge pclk);
      check("out0 phase", rt0, p[1:0]);
      check("out1 phase", rt1, exp1[p]);
    end
    check("out0 i", w0i, 7'h40);
    check("out0 q", w0q, 7'h3F);
    check("out1 i", w1i, 7'h20);
  endtask

  task automatic t_continuous;
    logic [1:0]  pre  [7] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
    logic [11:0] dv   [7] = '{12'h004, 12'h005, 12'h004, 12'h004, 12'h004, 12'h001, 12'h004};
    logic [1:0]  md   [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3};
    int          win  [7] = '{40, 40, 80, 160, 40, 40, 40};
    int          want [7] = '{10, 8, 10, 10, 0, 0, 0};
    for (int i = 0; i < 7; i++) begin
      setup(pre[i], 1'b1, {4'h1, dv[i]}, md[i]);
      repeat (20) @(posedge pclk);
      a = src.rises;
      repeat (win[i]) @(posedge pclk);
      check("continuous rises", src.rises - a, want[i]);
    end
  endtask

  task automatic t_clear;
    setup(2'h0, 1'b1, 16'h2004, MODE_PULSER);
    a = src.rises;
    apb(IDX_REQ, 1'b1, 16'h0301);
    repeat (40) @(posedge pclk);
    check("force under clear", src.rises - a, 0);
    apb(IDX_REQ, 1'b1, 16'h0300);
    repeat (40) @(posedge pclk);
    check("force after clear", src.rises - a, 2);
    apb(IDX_REQ, 1'b1, 16'h0201);
  endtask

  task automatic t_pulser;
    logic [3:0] cnt [4] = '{4'h1, 4'h3, 4'hF, 4'h0};
    for (int i = 0; i < 4; i++) begin
      setup(2'h0, 1'b1, {cnt[i], 12'h004}, MODE_PULSER);
      arm(16'h0200);
      a = src.rises;
      s = src.highs;
      src.send(2);
      repeat (80) @(posedge pclk);
      check("pulser pulses", src.rises - a, cnt[i]);
      check("pulser high cycles", src.highs - s, 2 * cnt[i]);
    end
    setup(2'h0, 1'b1, 16'h2004, MODE_PULSER);
    a = src.rises;
    src.send(2);
    repeat (30) @(posedge pclk);
    src.send(2);
    repeat (40) @(posedge pclk);
    check("pulser restart", src.rises - a, 4);
  endtask

  task automatic lat(input logic bp, input logic [5:0] st, output int l);
    setup(2'h0, bp, 16'h1004, MODE_REPEATER);
    arm({6'h00, 3'b100, st, 1'b0});
    a = src.rises;
    s = src.highs;
    src.send(3);
    repeat (80) @(posedge pclk);
    check("repeater pulses", src.rises - a, 1);
    check("repeater width", src.highs - s, 1);
    l = src.out_cyc - src.req_cyc;
  endtask

  task automatic t_repeater;
    lat(1'b1, 6'h00, l0);
    lat(1'b1, 6'h3F, l1);
    lat(1'b0, 6'h00, l2);
    check("delay steps", l1 - l0, 63);
    check("bypass latency", l2 - l0, 1);
    apb(IDX_REQ, 1'b1, 16'h027E);
    a = src.rises;
    // request still deep in the line when the clear pulse arrives
    src.send(2);
    arm(16'h027E);
    repeat (80) @(posedge pclk);
    check("flushed request", src.rises - a, 0);
  endtask

  // reset again in mid-run: registers must return to their reset values
  task automatic t_midreset;
    apb(IDX_PULSE_DIV, 1'b1, 16'h3006);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("pulse div re-reset", IDX_PULSE_DIV, RST_PULSE_DIV);
    rdchk("req re-reset", IDX_REQ, RST_REQ);
  endtask

  task automatic t_sync_latch;
    setup(2'h0, 1'b1, 16'h1004, MODE_PULSER);
    arm(16'h0000);
    a = src.rises;
    s = src.syncs;
    src.send(3);
    repeat (40) @(posedge pclk);
    check("sync rises", src.rises - a, 0);
    check("sync restart", src.syncs - s, 1);
    arm(16'h0280);
    src.send(2);
    repeat (30) @(posedge pclk);
    rdchk("latched status", IDX_STATUS, 16'h0003);
    a = src.rises;
    src.send(2);
    repeat (30) @(posedge pclk);
    check("latched no retrigger", src.rises - a, 0);
    apb(IDX_REQ, 1'b1, 16'h0281);
    apb(IDX_STATUS, 1'b0, 16'h0000);
    check("cleared status", rdata[1:0], 2'b00);
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_retimer;
    t_continuous;
    t_clear;
    t_pulser;
    t_repeater;
    t_sync_latch;
    t_midreset;
    check("outputs identical", src.diffs, 0);
    close_out;
  end

  initial begin
    repeat (30000) @(posedge pclk);
    error_cnt++;
    close_out;
  end
endmodule // sysref_generator_control_tb
